// File: hw/pea_eeprom_ctrl.sv
// eeprom access control register and access sequencing in the core clock domain
`timescale 1ns/1ps
// How it works
// - management reads and writes the control register at its management address
// - size, addressing width, device select and speed fields load from the synchronised strap inputs after reset
// - scan after hardware reset always, after soft reset only if enabled
// - access error sets the latching failure flag
// - signature record found sets latching read-only flag, else zero
// - detected eeprom sets latching presence flag, else zero
// - size field selects capacity, codes 0000 up to 1010, strapped after reset
// - addressing width bit chooses 11-bit or 16-bit addressing
// - device select bits give the serial bus device address
// - speed field sets serial clock rate 100k, 400k, 1M, 3.4M
// - direction bit 0 reads, 1 writes
// - launch bit starts access, stays 1 while pending, clears on completion
module pea_eeprom_ctrl (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic soft_reset_i,
   input wire logic [4:0] mgmt_addr_i,
   input wire logic mgmt_wr_i,
   input wire logic mgmt_rd_i,
   input wire logic [15:0] mgmt_wdata_i,
   output logic [15:0] mgmt_rdata_o,
   input wire logic [3:0] strap_size_i,
   input wire logic strap_addr_width_i,
   input wire logic [2:0] strap_device_sel_i,
   input wire logic [1:0] strap_speed_i,
   input wire logic access_done_i,
   input wire logic access_error_i,
   input wire logic memory_present_i,
   input wire logic signature_found_i,
   output logic scan_start_o,
   output logic access_start_o,
   output logic transfer_direction_o,
   output logic addressing_width_sel_o,
   output logic [2:0] device_select_bits_o,
   output logic [3:0] mem_size_o,
   output logic serial_clk_o
);
   // ****************************************
   // reset and strap synchronisers
   // ****************************************
   logic rst_meta_q, rst_n_q;
   logic [9:0] strap_meta_q, strap_q;
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end
   always_ff @(posedge core_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         strap_meta_q <= 10'h000;
         strap_q <= 10'h000;
      end else begin
         strap_meta_q <= {strap_size_i, strap_addr_width_i, strap_device_sel_i, strap_speed_i};
         strap_q <= strap_meta_q;
      end
   end

   // ****************************************
   // register state
   // ****************************************
   logic scan_soft_q, fail_q, sig_q, present_q, addr_w_q, dir_q, launch_q;
   logic [3:0] size_q;
   logic [2:0] dev_q;
   logic [1:0] speed_q;
   logic [1:0] boot_q;
   logic boot_done_q, scan_start_q, access_start_q;
   logic [15:0] rdata_q;
   pea_pkg::pea_state_t state_q, state_d;

   wire reg_hit = (mgmt_addr_i == pea_pkg::EEPROM_ACCESS_CONTROL_OFS);
   wire reg_wr = mgmt_wr_i && reg_hit;
   wire reg_rd = mgmt_rd_i && reg_hit;
   wire idle = (state_q == pea_pkg::PEA_IDLE);
   // fields only take writes while nothing is pending
   wire cfg_wr = reg_wr && idle && boot_done_q;
   wire launch_req = cfg_wr && mgmt_wdata_i[pea_pkg::BIT_LAUNCH];
   wire boot_fire = !boot_done_q && (boot_q == pea_pkg::BOOT_CYCLES);
   wire soft_scan = soft_reset_i && scan_soft_q && boot_done_q;
   wire scan_req = boot_fire || (soft_scan && idle);
   wire strap_load = boot_fire || (soft_reset_i && boot_done_q);
   wire [3:0] strap_size = strap_q[9:6];
   wire [2:0] strap_dev = strap_q[4:2];

   wire [15:0] reg_view = {scan_soft_q, fail_q, sig_q, present_q, size_q, addr_w_q, dev_q,
                           speed_q, dir_q, launch_q};

   // ****************************************
   // sequencing
   // ****************************************
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         pea_pkg::PEA_IDLE: begin
            if (scan_req) begin
               state_d = pea_pkg::PEA_SCAN;
            end else if (launch_req) begin
               state_d = pea_pkg::PEA_ACCESS;
            end
         end
         pea_pkg::PEA_SCAN: begin
            if (access_done_i) begin
               state_d = pea_pkg::PEA_IDLE;
            end
         end
         pea_pkg::PEA_ACCESS: begin
            if (access_done_i) begin
               state_d = pea_pkg::PEA_IDLE;
            end
         end
         default: begin
            state_d = pea_pkg::PEA_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= pea_pkg::PEA_IDLE;
         boot_q <= 2'h0;
         boot_done_q <= 1'b0;
         scan_start_q <= 1'b0;
         access_start_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (!boot_done_q) begin
            boot_q <= boot_q + 2'h1;
         end
         if (boot_fire) begin
            boot_done_q <= 1'b1;
         end
         scan_start_q <= scan_req && idle;
         access_start_q <= launch_req && !scan_req;
      end
   end

   // ****************************************
   // configuration fields
   // ****************************************
   logic [3:0] size_wr;
   assign size_wr = mgmt_wdata_i[pea_pkg::SIZE_HI:pea_pkg::SIZE_LO];
   always_ff @(posedge core_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         scan_soft_q <= pea_pkg::EEPROM_ACCESS_CONTROL_RST[pea_pkg::BIT_SCAN_SOFT];
         size_q <= pea_pkg::EEPROM_ACCESS_CONTROL_RST[pea_pkg::SIZE_HI:pea_pkg::SIZE_LO];
         addr_w_q <= pea_pkg::EEPROM_ACCESS_CONTROL_RST[pea_pkg::BIT_ADDR_WIDTH];
         dev_q <= pea_pkg::EEPROM_ACCESS_CONTROL_RST[pea_pkg::DEV_HI:pea_pkg::DEV_LO];
         speed_q <= pea_pkg::EEPROM_ACCESS_CONTROL_RST[pea_pkg::SPEED_HI:pea_pkg::SPEED_LO];
         dir_q <= pea_pkg::EEPROM_ACCESS_CONTROL_RST[pea_pkg::BIT_DIR];
      end else if (strap_load) begin
         // soft reset also reloads the strapped settings; scan enable survives it
         size_q <= (strap_size > pea_pkg::SIZE_MAX) ? pea_pkg::SIZE_MAX : strap_size;
         addr_w_q <= strap_q[5];
         dev_q <= strap_dev;
         speed_q <= strap_q[1:0];
         dir_q <= 1'b0;
      end else if (cfg_wr) begin
         scan_soft_q <= mgmt_wdata_i[pea_pkg::BIT_SCAN_SOFT];
         // codes above 1010 are not sizes; the old setting is kept
         if (size_wr <= pea_pkg::SIZE_MAX) begin
            size_q <= size_wr;
         end
         addr_w_q <= mgmt_wdata_i[pea_pkg::BIT_ADDR_WIDTH];
         dev_q <= mgmt_wdata_i[pea_pkg::DEV_HI:pea_pkg::DEV_LO];
         speed_q <= mgmt_wdata_i[pea_pkg::SPEED_HI:pea_pkg::SPEED_LO];
         dir_q <= mgmt_wdata_i[pea_pkg::BIT_DIR];
      end
   end

   // ****************************************
   // latched status and read path
   // ****************************************
   always_ff @(posedge core_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         fail_q <= 1'b0;
         sig_q <= 1'b0;
         present_q <= 1'b0;
         rdata_q <= 16'h0000;
      end else begin
         // a new event in the read cycle wins over the clear
         fail_q <= access_error_i || (fail_q && !reg_rd);
         sig_q <= signature_found_i || (sig_q && !reg_rd);
         present_q <= memory_present_i || (present_q && !reg_rd);
         if (mgmt_rd_i) begin
            rdata_q <= reg_hit ? reg_view : 16'h0000;
         end
      end
   end
   assign launch_q = (state_q == pea_pkg::PEA_ACCESS);

   // ****************************************
   // serial clock divider
   // ****************************************
   logic [pea_pkg::DIV_W-1:0] div_q, half_cnt;
   logic sclk_q;
   always_comb begin
      unique case (speed_q)
         2'h0: half_cnt = pea_pkg::DIV_W'(pea_pkg::HALF_100K);
         2'h1: half_cnt = pea_pkg::DIV_W'(pea_pkg::HALF_400K);
         2'h2: half_cnt = pea_pkg::DIV_W'(pea_pkg::HALF_1M);
         2'h3: half_cnt = pea_pkg::DIV_W'(pea_pkg::HALF_3M4);
      endcase
   end
   // clock idles high outside a transfer, as a two-wire bus expects
   always_ff @(posedge core_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         div_q <= '0;
         sclk_q <= 1'b1;
      end else if (idle) begin
         div_q <= '0;
         sclk_q <= 1'b1;
      end else if (div_q >= half_cnt - pea_pkg::DIV_W'(1)) begin
         div_q <= '0;
         sclk_q <= !sclk_q;
      end else begin
         div_q <= div_q + pea_pkg::DIV_W'(1);
      end
   end

   assign mgmt_rdata_o = rdata_q;
   assign scan_start_o = scan_start_q;
   assign access_start_o = access_start_q;
   assign transfer_direction_o = dir_q;
   assign addressing_width_sel_o = addr_w_q;
   assign device_select_bits_o = dev_q;
   assign mem_size_o = size_q;
   assign serial_clk_o = sclk_q;
endmodule

// File: hw/pea_pkg.sv
// package with register map, field layout and timing constants of the eeprom access control
package pea_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [4:0] EEPROM_ACCESS_CONTROL_OFS = 5'h16;
   localparam logic [15:0] EEPROM_ACCESS_CONTROL_RST = 16'h0000;
   localparam int BIT_SCAN_SOFT = 15;
   localparam int BIT_FAIL = 14;
   localparam int BIT_SIG = 13;
   localparam int BIT_PRESENT = 12;
   localparam int SIZE_HI = 11;
   localparam int SIZE_LO = 8;
   localparam int BIT_ADDR_WIDTH = 7;
   localparam int DEV_HI = 6;
   localparam int DEV_LO = 4;
   localparam int SPEED_HI = 3;
   localparam int SPEED_LO = 2;
   localparam int BIT_DIR = 1;
   localparam int BIT_LAUNCH = 0;
   localparam logic [3:0] SIZE_MAX = 4'hA;
   // ****************************************
   // serial clock timing
   // ****************************************
   localparam longint CORE_CLK_HZ = 125000000;
   localparam longint F_100K_HZ = 100000;
   localparam longint F_400K_HZ = 400000;
   localparam longint F_1M_HZ = 1000000;
   localparam longint F_3M4_HZ = 3400000;
   // half period rounded up so the rate never exceeds the selected one
   localparam longint HALF_100K = (CORE_CLK_HZ + 2 * F_100K_HZ - 1) / (2 * F_100K_HZ);
   localparam longint HALF_400K = (CORE_CLK_HZ + 2 * F_400K_HZ - 1) / (2 * F_400K_HZ);
   localparam longint HALF_1M = (CORE_CLK_HZ + 2 * F_1M_HZ - 1) / (2 * F_1M_HZ);
   localparam longint HALF_3M4 = (CORE_CLK_HZ + 2 * F_3M4_HZ - 1) / (2 * F_3M4_HZ);
   localparam int DIV_W = 10;
   localparam logic [1:0] BOOT_CYCLES = 2'h3;
   // ****************************************
   // control states
   // ****************************************
   typedef enum logic [2:0] {
      PEA_IDLE = 3'b001,
      PEA_SCAN = 3'b010,
      PEA_ACCESS = 3'b100
   } pea_state_t;
endpackage

// File: bench/pea_checker.sv
// port-level assertions for the eeprom access control
`timescale 1ns/1ps
module pea_checker (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic soft_reset_i,
   input wire logic [4:0] mgmt_addr_i,
   input wire logic mgmt_wr_i,
   input wire logic mgmt_rd_i,
   input wire logic [15:0] mgmt_wdata_i,
   input wire logic [15:0] mgmt_rdata_o,
   input wire logic access_done_i,
   input wire logic access_error_i,
   input wire logic memory_present_i,
   input wire logic signature_found_i,
   input wire logic access_start_o,
   input wire logic transfer_direction_o,
   input wire logic addressing_width_sel_o,
   input wire logic [2:0] device_select_bits_o,
   input wire logic [3:0] mem_size_o,
   input wire logic serial_clk_o
);
   logic [9:0] low_q;
   logic [4:0] age_q;
   wire logic hit = mgmt_addr_i == pea_pkg::EEPROM_ACCESS_CONTROL_OFS;
   // age lets the strap load after boot pass unchallenged
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         low_q <= 10'h000;
         age_q <= 5'h00;
      end else begin
         low_q <= serial_clk_o ? 10'h000 : low_q + 10'h001;
         age_q <= age_q + {4'h0, age_q != 5'h1F};
      end
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   AST_LAUNCH: assert property (
      access_start_o |-> $past(mgmt_wr_i && hit && mgmt_wdata_i[0])) else $error("stray start");
   AST_DIR: assert property (
      access_start_o |-> transfer_direction_o == $past(mgmt_wdata_i[1])) else $error("bad dir");
   AST_SIZE_MAX: assert property (
      mem_size_o <= pea_pkg::SIZE_MAX) else $error("size code out of range");
   AST_RD_OTHER: assert property (
      mgmt_rd_i && !hit |=> mgmt_rdata_o == 16'h0000) else $error("unmapped read not zero");
   AST_SCLK_HALF: assert property (
      $rose(serial_clk_o) && !$past(access_done_i) && !$past(access_done_i, 2)
      |-> low_q >= 10'h013) else $error("serial clock low phase too short");
   AST_FIELDS: assert property (
      $changed({mem_size_o, addressing_width_sel_o, device_select_bits_o}) |-> $past(mgmt_wr_i)
      || $past(soft_reset_i) || $past(soft_reset_i, 2) || age_q < 5'h10)
      else $error("fields moved without cause");
   AST_FAIL: assert property (
      access_error_i && !mgmt_rd_i ##1 mgmt_rd_i && hit |=> mgmt_rdata_o[14])
      else $error("failure flag lost");
   AST_SIG: assert property (
      signature_found_i && !mgmt_rd_i ##1 mgmt_rd_i && hit |=> mgmt_rdata_o[13])
      else $error("signature flag lost");
   AST_PRES: assert property (
      memory_present_i && !mgmt_rd_i ##1 mgmt_rd_i && hit |=> mgmt_rdata_o[12])
      else $error("presence flag lost");
endmodule
bind pea_eeprom_ctrl pea_checker u_pea_checker (.*);

// File: bench/pea_engine_model.sv
// serial engine and eeprom stand-in answering scans and single accesses
`timescale 1ns/1ps
module pea_engine_model (
   input wire logic clk_i,
   input wire logic scan_start_i,
   input wire logic access_start_i,
   input wire logic [7:0] delay_i,
   input wire logic fail_i,
   input wire logic sig_i,
   output logic done_o,
   output logic error_o,
   output logic sig_found_o
);
   logic [7:0] cnt_q = 8'h00;
   logic busy_q = 1'b0;
   logic scan_q = 1'b0;
   always_ff @(posedge clk_i) begin
      done_o <= 1'b0;
      error_o <= 1'b0;
      sig_found_o <= 1'b0;
      if (scan_start_i || access_start_i) begin
         busy_q <= 1'b1;
         scan_q <= scan_start_i;
         cnt_q <= delay_i;
      end else if (busy_q && cnt_q != 8'h00) begin
         cnt_q <= cnt_q - 8'h01;
      end else if (busy_q) begin
         busy_q <= 1'b0;
         done_o <= 1'b1;
         error_o <= fail_i && !scan_q;
         sig_found_o <= sig_i && scan_q;
      end
   end
endmodule

// File: bench/phy_eeprom_access_control_test.sv
// self-checking bench for the eeprom access control
`timescale 1ns/1ps
module phy_eeprom_access_control_test;
   logic core_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic soft_reset_i = 1'b0;
   logic [4:0] mgmt_addr_i = 5'h00;
   logic mgmt_wr_i = 1'b0;
   logic mgmt_rd_i = 1'b0;
   logic [15:0] mgmt_wdata_i = 16'h0000;
   logic [3:0] strap_size_i, mem_size_o, sz;
   logic [2:0] strap_device_sel_i, device_select_bits_o, dv;
   logic [1:0] strap_speed_i, sp;
   logic strap_addr_width_i, aw, dr, scan_start_o, access_start_o, serial_clk_o;
   logic access_done_i, access_error_i, signature_found_i, transfer_direction_o;
   logic addressing_width_sel_o;
   logic memory_present_i = 1'b1;
   logic fail = 1'b0;
   logic rd_pend = 1'b0;
   logic [15:0] mgmt_rdata_o;
   logic [15:0] exp_q[$];
   int n_errors = 0;
   int n_checks = 0;
   int cycles = 0;
   localparam logic [4:0] OFS = pea_pkg::EEPROM_ACCESS_CONTROL_OFS;
   always #4 core_clk_i = ~core_clk_i;
   pea_eeprom_ctrl DUT (.*);
   pea_engine_model u_engine (.clk_i(core_clk_i), .scan_start_i(scan_start_o),
      .access_start_i(access_start_o), .delay_i(8'h40), .fail_i(fail), .sig_i(1'b1),
      .done_o(access_done_i), .error_o(access_error_i), .sig_found_o(signature_found_i));
   // ***************************************
   // bus tasks and comparison
   // ***************************************
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [15:0] word(input logic s, input logic [2:0] f, input logic go);
      return {s, f, sz, aw, dv, sp, dr, go};
   endfunction
   task automatic wr(input logic [15:0] d);
      mgmt_addr_i <= OFS;
      mgmt_wdata_i <= d;
      mgmt_wr_i <= 1'b1;
      @(posedge core_clk_i);
      mgmt_wr_i <= 1'b0;
      @(posedge core_clk_i);
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      mgmt_addr_i <= a;
      mgmt_rd_i <= 1'b1;
      @(posedge core_clk_i);
      mgmt_rd_i <= 1'b0;
      @(posedge core_clk_i);
   endtask
   // returns on the edge that shows done, so a read can follow at once
   task automatic wait_done();
      int k;
      k = 0;
      while (access_done_i !== 1'b1 && k < 3000) begin
         @(posedge core_clk_i);
         k++;
      end
      if (k == 3000) n_errors++;
   endtask
   task automatic straps();
      {sz, aw, dv, sp} = 10'($urandom);
      strap_size_i <= sz;
      strap_addr_width_i <= aw;
      strap_device_sel_i <= dv;
      strap_speed_i <= sp;
      if (sz > pea_pkg::SIZE_MAX) sz = pea_pkg::SIZE_MAX;
      dr = 1'b0;
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge core_clk_i) begin
      if (rd_pend) check("register word", mgmt_rdata_o, exp_q.pop_front());
      rd_pend = mgmt_rd_i;
   end
   initial begin
      while (cycles < 20000) begin
         @(posedge core_clk_i);
         cycles++;
      end
      n_errors++;
      tally_and_finish();
   end
   initial begin
      int n;
      void'($urandom(6660));
      straps();
      repeat (20) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      wait_done();
      rd(OFS, word(1'b0, 3'b011, 1'b0));
      rd(OFS, word(1'b0, 3'b001, 1'b0));
      rd(5'h15, 16'h0000);
      for (int k = 0; k < 12; k++) begin
         aw = k[0];
         wr({4'h0, 4'(k), aw, dv, sp, 2'b00});
         if (k <= 10) sz = 4'(k);
         rd(OFS, word(1'b0, 3'b001, 1'b0));
         check("size out", 16'(mem_size_o), 16'(sz));
         check("width out", 16'(addressing_width_sel_o), 16'(aw));
      end
      for (int i = 0; i < 8; i++) begin
         sp = i[1:0];
         dr = i[2];
         fail <= (i == 6);
         dv = 3'($urandom);
         wr(word(1'b0, 3'b111, 1'b1));
         check("start pulse", 16'(access_start_o), 16'h0001);
         rd(OFS, word(1'b0, 3'b001, 1'b1));
         wr(~word(1'b0, 3'b000, 1'b1));
         wait_done();
         rd(OFS, word(1'b0, {i == 6, 2'b01}, 1'b0));
         check("device out", 16'(device_select_bits_o), 16'(dv));
         check("direction out", 16'(transfer_direction_o), 16'(dr));
         check("serial idle", 16'(serial_clk_o), 16'h0001);
      end
      fail <= 1'b0;
      for (int j = 0; j < 2; j++) begin
         wr({j[0], 15'h0000});
         straps();
         repeat (4) @(posedge core_clk_i);
         soft_reset_i <= 1'b1;
         @(posedge core_clk_i);
         soft_reset_i <= 1'b0;
         n = 0;
         repeat (4) begin
            @(posedge core_clk_i);
            n += scan_start_o;
         end
         check("soft scan", 16'(n), 16'(j));
         if (j == 1) wait_done();
         rd(OFS, word(j[0], {1'b0, j[0], 1'b1}, 1'b0));
      end
      // memory gone: flag holds until read, then follows the condition
      memory_present_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      rd(OFS, word(1'b1, 3'b001, 1'b0));
      rd(OFS, word(1'b1, 3'b000, 1'b0));
      tally_and_finish();
   end
endmodule
